/* File: src/osdm_pkg.sv */
// Package: register map, field positions, reset values and timing counts
// for the display-memory and glyph-store access logic.
// Assumes a single 125 MHz system clock shared by every user of the package.
package osdm_pkg;
  // Write offsets; the read offset of each register is the write offset plus READ_FLAG
  localparam logic [7:0] ADDR_DISP_HIGH   = 8'h05;
  localparam logic [7:0] ADDR_DISP_LOW    = 8'h06;
  localparam logic [7:0] ADDR_DISP_DATA   = 8'h07;
  localparam logic [7:0] ADDR_GLYPH_CMD   = 8'h08;
  localparam logic [7:0] ADDR_GLYPH_INDEX = 8'h09;
  localparam logic [7:0] ADDR_GLYPH_BYTE  = 8'h0A;
  localparam logic [7:0] ADDR_GLYPH_DATA  = 8'h0B;
  localparam logic [7:0] READ_FLAG        = 8'h80;

  // Reset values
  localparam logic [7:0] RST_BYTE = 8'h00;

  // Field positions
  localparam int DISP_HIGH_MSB_BIT   = 0;
  localparam int DISP_HIGH_SEL_BIT   = 1;
  localparam int ATTR_LOCAL_BG_BIT   = 7;
  localparam int ATTR_BLINK_BIT      = 6;
  localparam int ATTR_INVERT_BIT     = 5;
  localparam int CMD_NIBBLE_LSB      = 4;
  localparam int GLYPH_BYTE_IDX_W    = 6;

  // Command codes in the upper nibble of the glyph store command
  localparam logic [3:0] CMD_STORE_NVM = 4'hA;
  localparam logic [3:0] CMD_LOAD_NVM  = 4'h5;

  // Glyph code reserved as escape during auto-increment
  localparam logic [7:0] ESCAPE_CODE = 8'hFF;

  // Geometry
  localparam int DISP_DEPTH   = 512;
  localparam int GLYPH_COUNT  = 256;
  localparam int SHADOW_BYTES = 64;

  // Timing
  localparam int CLK_MHZ         = 125;
  localparam int CLEAR_TIME_NS   = 20000;
  localparam int LOAD_TIME_NS    = 500;
  localparam int STORE_TIME_MS   = 12;
  localparam int CLEAR_CYCLES    = (CLEAR_TIME_NS * CLK_MHZ) / 1000;
  localparam int LOAD_CYCLES     = (LOAD_TIME_NS * CLK_MHZ) / 1000;
  localparam int STORE_CYCLES    = STORE_TIME_MS * 1000 * CLK_MHZ;

  typedef enum logic [1:0] {
    GS_IDLE,
    GS_LOAD,
    GS_STORE
  } osdm_glyph_state_t;
endpackage : osdm_pkg

/* File: src/osdm_glyph_nvm.sv */
// Nonvolatile glyph array: one whole character line per entry.
// Assumes the caller only moves whole lines and sequences the busy time itself.
`timescale 1ns/1ps
module osdm_glyph_nvm
  import osdm_pkg::*;
#(
  parameter int DEPTH  = GLYPH_COUNT,
  parameter int LINE_W = SHADOW_BYTES * 8
) (
  input  wire logic                     clk,
  input  wire logic                     resetn,
  input  wire logic                     ce,
  input  wire logic                     wr_en,
  input  wire logic                     rd_en,
  input  wire logic [$clog2(DEPTH)-1:0] index,
  input  wire logic [LINE_W-1:0]        wr_line,
  output logic      [LINE_W-1:0]        rd_line,
  output logic                          rd_valid
);
  if (DEPTH < 2 || LINE_W < 8) begin : g_check
    $error("osdm_glyph_nvm: unsupported geometry");
  end

  // Storage keeps its content across reset, as a nonvolatile array would
  logic [LINE_W-1:0] cells [DEPTH];

  always_ff @(posedge clk) begin
    if (ce && wr_en) begin
      cells[index] <= wr_line;
    end
  end

  // Registered read; valid marks the cycle the line may be captured
  always_ff @(posedge clk) begin
    if (!resetn) begin
      rd_line  <= '0;
      rd_valid <= 1'b0;
    end else if (ce) begin
      rd_valid <= rd_en;
      if (rd_en) begin
        rd_line <= cells[index];
      end
    end
  end
endmodule : osdm_glyph_nvm

/* File: src/osdm_memory_access.sv */
// Display-memory and glyph-store register access for an on-screen display.
// Assumes a serial front end that presents decoded byte writes and reads,
// synchronous to clk, and a renderer that reads display memory by position.
//
// Overview of operation
// - Video background only: external sync, both bits 0
// - Display address/data writes blocked during clear
// - 8-bit mode: select bit picks glyph/attribute
// - Nine-bit address from high bit 0, low byte
// - Attribute byte: bit7 background, 6 blink, 5 invert
// - 16-bit mode: data byte always glyph code
// - All-ones glyph code ends auto-increment, not stored
// - All-ones stored normally outside auto-increment
// - Command writes need idle store, display off
// - Whole characters move through 64-byte shadow
// - Code 1010 stores shadow, busy about 12 ms
// - Store end clears command and busy
// - Code 0101 loads shadow, busy about 0.5 us
// - Locked-out commands ignored, registers unchanged
// - Every register readable at any time
// - Glyph index selects character, byte index byte
// - Read address is write address plus 80h
// - Clear zeroes memory, about 20 us, self-clearing
// - Auto-increment starts at current address
`timescale 1ns/1ps
module osdm_memory_access
  import osdm_pkg::*;
#(
  parameter int ADDR_W         = 9,
  parameter int STORE_CYC      = STORE_CYCLES,
  parameter int CLEAR_CYC      = CLEAR_CYCLES
) (
  input  wire logic              clk,
  input  wire logic              resetn,
  input  wire logic              ce,
  input  wire logic              reg_wr_en,
  input  wire logic [7:0]        reg_wr_addr,
  input  wire logic [7:0]        reg_wr_data,
  input  wire logic              reg_rd_en,
  input  wire logic [7:0]        reg_rd_addr,
  output logic      [7:0]        reg_rd_data,
  output logic                   reg_rd_valid,
  input  wire logic              display_access_mode_8bit,
  input  wire logic [2:0]        display_attr_16,
  input  wire logic              auto_inc_start,
  input  wire logic              clear_start,
  input  wire logic              osd_enable,
  input  wire logic              sync_external,
  input  wire logic              video_mode_background,
  input  wire logic              local_background_bit,
  output logic                   clear_busy,
  output logic                   auto_inc_active,
  output logic                   glyph_busy,
  output logic                   bg_shows_video,
  input  wire logic [ADDR_W-1:0] disp_rd_addr,
  output logic      [7:0]        disp_glyph_code,
  output logic      [2:0]        disp_attr
);
  localparam int LINE_W = SHADOW_BYTES * 8;
  localparam int CNT_W  = $clog2(STORE_CYC + 1);
  localparam int CLR_W  = $clog2(CLEAR_CYC + 1);

  if (ADDR_W != 9 || STORE_CYC < LOAD_CYCLES || CLEAR_CYC < DISP_DEPTH) begin : g_check
    $error("osdm_memory_access: parameters out of range");
  end

  // Register state
  logic [1:0]              disp_high_q;
  logic [7:0]              disp_low_q;
  logic [7:0]              disp_data_q;
  logic [7:0]              glyph_cmd_q;
  logic [7:0]              glyph_index_q;
  logic [7:0]              glyph_byte_q;
  logic [LINE_W-1:0]       shadow_q;
  logic                    auto_q;
  logic [ADDR_W-1:0]       auto_addr_q;
  logic                    clear_q;
  logic [CLR_W-1:0]        clr_idx_q;
  osdm_glyph_state_t       gs_q;
  logic [CNT_W-1:0]        op_cnt_q;
  logic [LINE_W-1:0]       nvm_line;
  logic                    nvm_valid;

  // Display memory: glyph code plus three attribute bits per position
  logic [7:0]              mem_code [DISP_DEPTH];
  logic [2:0]              mem_attr [DISP_DEPTH];

  // Write address decode
  wire hit_high  = reg_wr_en && (reg_wr_addr == ADDR_DISP_HIGH);
  wire hit_low   = reg_wr_en && (reg_wr_addr == ADDR_DISP_LOW);
  wire hit_data  = reg_wr_en && (reg_wr_addr == ADDR_DISP_DATA);
  wire hit_cmd   = reg_wr_en && (reg_wr_addr == ADDR_GLYPH_CMD);
  wire hit_index = reg_wr_en && (reg_wr_addr == ADDR_GLYPH_INDEX);
  wire hit_byte  = reg_wr_en && (reg_wr_addr == ADDR_GLYPH_BYTE);
  wire hit_gdata = reg_wr_en && (reg_wr_addr == ADDR_GLYPH_DATA);

  wire disp_wr_ok  = !clear_q;
  wire glyph_wr_ok = (gs_q == GS_IDLE) && !osd_enable;

  wire [ADDR_W-1:0] manual_addr = {disp_high_q[DISP_HIGH_MSB_BIT], disp_low_q};
  wire [ADDR_W-1:0] cur_addr    = auto_q ? auto_addr_q : manual_addr;

  // byte select only in 8-bit mode
  wire sel_attr = display_access_mode_8bit && disp_high_q[DISP_HIGH_SEL_BIT];
  wire data_wr  = hit_data && disp_wr_ok;
  // 16-bit writes are always glyph codes
  wire code_wr  = data_wr && !sel_attr;
  // escape ends auto mode; stored otherwise
  wire is_escape = code_wr && auto_q && (reg_wr_data == ESCAPE_CODE);
  wire mem_code_we = code_wr && !is_escape;
  wire mem_attr_we = (data_wr && sel_attr) || (mem_code_we && !display_access_mode_8bit);
  wire [2:0] attr_8bit = {reg_wr_data[ATTR_LOCAL_BG_BIT], reg_wr_data[ATTR_BLINK_BIT],
                          reg_wr_data[ATTR_INVERT_BIT]};
  wire [2:0] attr_in   = display_access_mode_8bit ? attr_8bit : display_attr_16;

  // Clear sweep writes one position per cycle, then idles out the rest
  wire clr_we   = clear_q && (clr_idx_q < CLR_W'(DISP_DEPTH));
  wire clr_last = clear_q && (clr_idx_q == CLR_W'(CLEAR_CYC - 1));
  wire clr_go   = clear_start && !clear_q;

  wire cmd_wr    = hit_cmd && glyph_wr_ok;
  wire [3:0] cmd_nib = reg_wr_data[CMD_NIBBLE_LSB +: 4];
  wire go_store  = cmd_wr && (cmd_nib == CMD_STORE_NVM);
  wire go_load   = cmd_wr && (cmd_nib == CMD_LOAD_NVM);
  wire op_done   = (gs_q != GS_IDLE) && (op_cnt_q == '0);

  wire [GLYPH_BYTE_IDX_W-1:0] byte_sel = glyph_byte_q[GLYPH_BYTE_IDX_W-1:0];
  wire [7:0] shadow_byte = shadow_q[byte_sel * 8 +: 8];

  // read decode at write offset plus 80h
  wire [7:0] rd_off  = reg_rd_addr ^ READ_FLAG;
  wire       rd_map  = reg_rd_addr[7];
  logic [7:0] rd_mux;

  always_comb begin
    rd_mux = RST_BYTE;
    if (rd_map) begin
      case (rd_off)
        ADDR_DISP_HIGH:   rd_mux = {6'h00, disp_high_q};
        ADDR_DISP_LOW:    rd_mux = disp_low_q;
        ADDR_DISP_DATA:   rd_mux = disp_data_q;
        ADDR_GLYPH_CMD:   rd_mux = glyph_cmd_q;
        ADDR_GLYPH_INDEX: rd_mux = glyph_index_q;
        ADDR_GLYPH_BYTE:  rd_mux = {2'h0, byte_sel};
        ADDR_GLYPH_DATA:  rd_mux = shadow_byte;
        default:          rd_mux = RST_BYTE;
      endcase
    end
  end

  // Read answer one cycle after the request; unmapped offsets read zero
  always_ff @(posedge clk) begin
    if (!resetn) begin
      reg_rd_data  <= RST_BYTE;
      reg_rd_valid <= 1'b0;
    end else if (ce) begin
      reg_rd_valid <= reg_rd_en;
      if (reg_rd_en) begin
        reg_rd_data <= rd_mux;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      disp_high_q <= 2'h0;
      disp_low_q  <= RST_BYTE;
      disp_data_q <= RST_BYTE;
    end else if (ce && disp_wr_ok) begin
      if (hit_high) disp_high_q <= reg_wr_data[1:0];
      if (hit_low)  disp_low_q  <= reg_wr_data;
      if (hit_data) disp_data_q <= reg_wr_data;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      auto_q      <= 1'b0;
      auto_addr_q <= '0;
    end else if (ce) begin
      if (clr_go) begin
        auto_q <= 1'b0;       // Clear cancels auto mode
      end else if (auto_inc_start && !auto_q) begin
        auto_q      <= 1'b1;
        auto_addr_q <= manual_addr;
      end else if (is_escape) begin
        auto_q <= 1'b0;
      end else if (auto_q && (mem_code_we || mem_attr_we)) begin
        auto_addr_q <= auto_addr_q + 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      clear_q   <= 1'b0;
      clr_idx_q <= '0;
    end else if (ce) begin
      if (clr_go) begin
        clear_q   <= 1'b1;
        clr_idx_q <= '0;
      end else if (clr_last) begin
        clear_q <= 1'b0;
      end else if (clear_q) begin
        clr_idx_q <= clr_idx_q + 1'b1;
      end
    end
  end

  // Display memory writes; clear and host never overlap since host is blocked
  always_ff @(posedge clk) begin
    if (ce) begin
      if (clr_we) begin
        mem_code[clr_idx_q[ADDR_W-1:0]] <= 8'h00;
        mem_attr[clr_idx_q[ADDR_W-1:0]] <= 3'h0;
      end else begin
        if (mem_code_we) mem_code[cur_addr] <= reg_wr_data;
        if (mem_attr_we) mem_attr[cur_addr] <= attr_in;
      end
    end
  end

  // Renderer read port and background pixel choice
  always_ff @(posedge clk) begin
    if (!resetn) begin
      disp_glyph_code <= 8'h00;
      disp_attr       <= 3'h0;
      bg_shows_video  <= 1'b0;
    end else if (ce) begin
      disp_glyph_code <= mem_code[disp_rd_addr];
      disp_attr       <= mem_attr[disp_rd_addr];
      // gray unless external, both bits low
      bg_shows_video  <= sync_external && !video_mode_background && !local_background_bit;
    end
  end

  // glyph index registers share the command lockout
  always_ff @(posedge clk) begin
    if (!resetn) begin
      glyph_index_q <= RST_BYTE;
      glyph_byte_q  <= RST_BYTE;
    end else if (ce && glyph_wr_ok) begin
      if (hit_index) glyph_index_q <= reg_wr_data;
      if (hit_byte)  glyph_byte_q  <= reg_wr_data;
    end
  end

  // shadow line: host bytes in, whole line from the array
  always_ff @(posedge clk) begin
    if (!resetn) begin
      shadow_q <= '0;
    end else if (ce) begin
      if (nvm_valid) begin
        shadow_q <= nvm_line;
      end else if (hit_gdata && glyph_wr_ok) begin
        shadow_q[byte_sel * 8 +: 8] <= reg_wr_data;
      end
    end
  end

  // Glyph store sequencer; the busy window models the array's store or load time
  always_ff @(posedge clk) begin
    if (!resetn) begin
      gs_q        <= GS_IDLE;
      op_cnt_q    <= '0;
      glyph_cmd_q <= RST_BYTE;
    end else if (ce) begin
      case (gs_q)
        GS_IDLE: begin
          if (cmd_wr) glyph_cmd_q <= reg_wr_data;
          if (go_store) begin
            gs_q     <= GS_STORE;
            op_cnt_q <= CNT_W'(STORE_CYC - 1);
          end else if (go_load) begin
            gs_q     <= GS_LOAD;
            op_cnt_q <= CNT_W'(LOAD_CYCLES - 1);
          end
        end
        GS_LOAD, GS_STORE: begin
          if (op_done) begin
            gs_q        <= GS_IDLE;
            glyph_cmd_q <= RST_BYTE;
          end else begin
            op_cnt_q <= op_cnt_q - 1'b1;
          end
        end
        default: gs_q <= GS_IDLE;
      endcase
    end
  end

  // character chosen by the glyph index
  osdm_glyph_nvm #(
    .DEPTH  (GLYPH_COUNT),
    .LINE_W (LINE_W)
  ) u_nvm (
    .clk      (clk),
    .resetn   (resetn),
    .ce       (ce),
    .wr_en    (go_store),
    .rd_en    (go_load),
    .index    (glyph_index_q),
    .wr_line  (shadow_q),
    .rd_line  (nvm_line),
    .rd_valid (nvm_valid)
  );

  // Status outputs straight from state flops
  assign clear_busy      = clear_q;
  assign auto_inc_active = auto_q;
  assign glyph_busy      = (gs_q != GS_IDLE);
endmodule : osdm_memory_access

/* File: verification/osdm_checker.sv */
// Checker: register answer, busy lengths, lockouts and background choice.
// Assumes it is bound to osdm_memory_access and sees only its ports.
`timescale 1ns/1ps
module osdm_checker
  import osdm_pkg::*;
#(
  parameter int STORE_CYC = 100,
  parameter int CLEAR_CYC = 600
) (
  input wire logic       clk,
  input wire logic       resetn,
  input wire logic       ce,
  input wire logic       reg_wr_en,
  input wire logic [7:0] reg_wr_addr,
  input wire logic [7:0] reg_wr_data,
  input wire logic       reg_rd_en,
  input wire logic [7:0] reg_rd_addr,
  input wire logic [7:0] reg_rd_data,
  input wire logic       reg_rd_valid,
  input wire logic       display_access_mode_8bit,
  input wire logic       auto_inc_start,
  input wire logic       clear_start,
  input wire logic       osd_enable,
  input wire logic       sync_external,
  input wire logic       video_mode_background,
  input wire logic       local_background_bit,
  input wire logic       clear_busy,
  input wire logic       auto_inc_active,
  input wire logic       glyph_busy,
  input wire logic       bg_shows_video
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);

  logic [20:0] gcnt_q;
  logic [20:0] ccnt_q;
  // Glyph command writes while the store is not busy, and display data writes outside a clear
  wire logic gwr = ce && reg_wr_en && reg_wr_addr == ADDR_GLYPH_CMD && !glyph_busy;
  wire logic dwr = ce && reg_wr_en && reg_wr_addr == ADDR_DISP_DATA && !clear_busy;

  // Busy-length counters; long counts would not unroll as repetitions
  always_ff @(posedge clk) begin
    if (!resetn) begin
      gcnt_q <= '0;
      ccnt_q <= '0;
    end else if (ce) begin
      gcnt_q <= glyph_busy ? gcnt_q + 21'h1 : '0;
      ccnt_q <= clear_busy ? ccnt_q + 21'h1 : '0;
    end
  end

  a_read_answer_next: assert property (ce && reg_rd_en |=> reg_rd_valid)
    else $error("read request not answered next cycle");
  a_unmapped_reads_zero: assert property (ce && reg_rd_en && reg_rd_addr == 8'h84 |=> reg_rd_data == 8'h00)
    else $error("unmapped read not zero");
  a_bg_video_choice: assert property (ce |=> bg_shows_video == ($past(sync_external) &&
      !$past(video_mode_background) && !$past(local_background_bit))) else $error("background choice wrong");
  a_load_busy_time: assert property (gwr && !osd_enable && reg_wr_data[7:4] == CMD_LOAD_NVM
      |=> glyph_busy ##61 glyph_busy ##1 !glyph_busy) else $error("load busy length wrong");
  a_glyph_busy_len: assert property ($fell(glyph_busy) && $past(resetn)
      |-> gcnt_q == STORE_CYC || gcnt_q == LOAD_CYCLES) else $error("glyph busy length wrong");
  a_osd_lock_cmd: assert property (gwr && osd_enable |=> !glyph_busy)
    else $error("command accepted while display on");
  a_clear_busy_len: assert property ($fell(clear_busy) && $past(resetn) |-> ccnt_q == CLEAR_CYC)
    else $error("clear busy length wrong");
  a_clear_drops_auto: assert property (ce && clear_start && !clear_busy |=> clear_busy && !auto_inc_active)
    else $error("clear did not start or auto mode kept");
  a_auto_starts: assert property (ce && auto_inc_start && !clear_start && !clear_busy |=> auto_inc_active)
    else $error("auto mode not started");
  a_escape_ends_auto: assert property (dwr && auto_inc_active && !display_access_mode_8bit
      && reg_wr_data == ESCAPE_CODE |=> !auto_inc_active) else $error("escape kept auto mode");
endmodule : osdm_checker

/* File: verification/osdm_host.sv */
// Host model: byte writes and reads on the register port.
// Assumes requests change 1 ns after the rising clk edge.
`timescale 1ns/1ps
module osdm_host (
  input  wire logic       clk,
  input  wire logic [7:0] reg_rd_data,
  input  wire logic       reg_rd_valid,
  input  wire logic       clear_busy,
  input  wire logic       glyph_busy,
  output logic            reg_wr_en,
  output logic [7:0]      reg_wr_addr,
  output logic [7:0]      reg_wr_data,
  output logic            reg_rd_en,
  output logic [7:0]      reg_rd_addr
);
  // Quiet bus at time zero
  initial begin
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b0;
    reg_wr_addr = 8'h00;
    reg_wr_data = 8'h00;
    reg_rd_addr = 8'h00;
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #1 reg_wr_en = 1'b1;
    reg_wr_addr = a;
    reg_wr_data = d;
    @(posedge clk);
    #1 reg_wr_en = 1'b0;
    reg_wr_data = ~d; // Released data never shows the old byte
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
    @(posedge clk);
    #1 reg_rd_en = 1'b1;
    reg_rd_addr = a;
    @(posedge clk);
    #1 reg_rd_en = 1'b0;
    d = reg_rd_data;
    v = reg_rd_valid;
  endtask : rd

  task automatic wait_idle(output logic ok);
    ok = 1'b0;
    for (int n = 0; n < 2000 && !ok; n++) begin
      @(posedge clk);
      #1 ok = !clear_busy && !glyph_busy;
    end
  endtask : wait_idle
endmodule : osdm_host

/* File: verification/osdm_memory_access_registers_test.sv */
// Testbench: register, display-memory, glyph-store and background tests.
// Assumes the design, its package, the host model and the checker.
`timescale 1ns/1ps
module osd_memory_access_registers_test;
  import osdm_pkg::*;
  logic       clk, resetn, ce, reg_wr_en, reg_rd_en, reg_rd_valid, ok;
  logic [7:0] reg_wr_addr, reg_wr_data, reg_rd_addr, reg_rd_data, disp_glyph_code;
  logic       display_access_mode_8bit, auto_inc_start, clear_start, osd_enable;
  logic       sync_external, video_mode_background, local_background_bit;
  logic       clear_busy, auto_inc_active, glyph_busy, bg_shows_video;
  logic [2:0] display_attr_16, disp_attr;
  logic [8:0] disp_rd_addr;
  int         failures, checks_done, cycles;

  osdm_memory_access #(.STORE_CYC(100), .CLEAR_CYC(600)) osdm_memory_access_inst (
    .clk(clk),
    .resetn(resetn),
    .ce(ce),
    .reg_wr_en(reg_wr_en),
    .reg_wr_addr(reg_wr_addr),
    .reg_wr_data(reg_wr_data),
    .reg_rd_en(reg_rd_en),
    .reg_rd_addr(reg_rd_addr),
    .reg_rd_data(reg_rd_data),
    .reg_rd_valid(reg_rd_valid),
    .display_access_mode_8bit(display_access_mode_8bit),
    .display_attr_16(display_attr_16),
    .auto_inc_start(auto_inc_start),
    .clear_start(clear_start),
    .osd_enable(osd_enable),
    .sync_external(sync_external),
    .video_mode_background(video_mode_background),
    .local_background_bit(local_background_bit),
    .clear_busy(clear_busy),
    .auto_inc_active(auto_inc_active),
    .glyph_busy(glyph_busy),
    .bg_shows_video(bg_shows_video),
    .disp_rd_addr(disp_rd_addr),
    .disp_glyph_code(disp_glyph_code),
    .disp_attr(disp_attr)
  );
  osdm_host osdm_host_inst (
    .clk(clk),
    .reg_rd_data(reg_rd_data),
    .reg_rd_valid(reg_rd_valid),
    .clear_busy(clear_busy),
    .glyph_busy(glyph_busy),
    .reg_wr_en(reg_wr_en),
    .reg_wr_addr(reg_wr_addr),
    .reg_wr_data(reg_wr_data),
    .reg_rd_en(reg_rd_en),
    .reg_rd_addr(reg_rd_addr)
  );

  // Free-running 125 MHz clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic chk(input string w, input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", w, e, g);
    end
  endtask : chk

  task automatic rdc(input logic [7:0] a, input logic [7:0] e, input string w);
    logic [7:0] d;
    logic       v;
    osdm_host_inst.rd(a, d, v);
    chk("read valid", 8'h01, {7'h00, v});
    chk(w, e, d);
  endtask : rdc

  task automatic pulse(ref logic s);
    @(posedge clk);
    #1 s = 1'b1;
    @(posedge clk);
    #1 s = 1'b0;
  endtask : pulse

  // Content is checked two edges after the position is presented
  task automatic shows(input logic [8:0] a, input logic [7:0] g, input logic [2:0] t);
    disp_rd_addr = a;
    @(posedge clk);
    @(posedge clk);
    #1 chk("glyph", g, disp_glyph_code);
    chk("attr", {5'h00, t}, {5'h00, disp_attr});
  endtask : shows

  task automatic end_of_test;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : end_of_test

  // Hang guard, far above the fewer than one thousand cycles needed
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      end_of_test();
    end
  end

  // Main sequence
  initial begin
    {resetn, auto_inc_start, clear_start, osd_enable, display_access_mode_8bit} = 5'h00;
    {sync_external, video_mode_background, local_background_bit} = 3'h0;
    ce = 1'b1;
    display_attr_16 = 3'h5;
    disp_rd_addr = 9'h000;
    repeat (6) @(posedge clk);
    #1 resetn = 1'b1;
    for (int i = 0; i < 4; i++) rdc(8'h85 + 8'(i), 8'h00, "reset value");
    rdc(8'h84, 8'h00, "unmapped");
    pulse(clear_start);
    osdm_host_inst.wr(ADDR_DISP_LOW, 8'h55);
    osdm_host_inst.wait_idle(ok);
    chk("clear idle", 8'h01, {7'h00, ok});
    rdc(8'h86, 8'h00, "low locked");
    shows(9'h123, 8'h00, 3'h0);
    osdm_host_inst.wr(ADDR_DISP_HIGH, 8'h03);
    osdm_host_inst.wr(ADDR_DISP_LOW, 8'h23);
    osdm_host_inst.wr(ADDR_DISP_DATA, 8'h41);
    shows(9'h123, 8'h41, 3'h5);
    display_access_mode_8bit = 1'b1;
    osdm_host_inst.wr(ADDR_DISP_DATA, 8'hE0);
    shows(9'h123, 8'h41, 3'h7);
    osdm_host_inst.wr(ADDR_DISP_HIGH, 8'h01);
    osdm_host_inst.wr(ADDR_DISP_DATA, 8'hFF);
    shows(9'h123, 8'hFF, 3'h7);
    rdc(8'h85, 8'h01, "high");
    display_access_mode_8bit = 1'b0;
    display_attr_16 = 3'h2;
    osdm_host_inst.wr(ADDR_DISP_HIGH, 8'h00);
    osdm_host_inst.wr(ADDR_DISP_LOW, 8'h10);
    pulse(auto_inc_start);
    osdm_host_inst.wr(ADDR_DISP_DATA, 8'h11);
    osdm_host_inst.wr(ADDR_DISP_DATA, 8'h22);
    osdm_host_inst.wr(ADDR_DISP_DATA, 8'hFF);
    chk("auto off", 8'h00, {7'h00, auto_inc_active});
    shows(9'h010, 8'h11, 3'h2);
    shows(9'h011, 8'h22, 3'h2);
    shows(9'h012, 8'h00, 3'h0);
    osd_enable = 1'b1;
    osdm_host_inst.wr(ADDR_GLYPH_CMD, 8'h50);
    chk("locked busy", 8'h00, {7'h00, glyph_busy});
    rdc(8'h88, 8'h00, "locked cmd");
    osd_enable = 1'b0;
    osdm_host_inst.wr(ADDR_GLYPH_INDEX, 8'h07);
    osdm_host_inst.wr(ADDR_GLYPH_BYTE, 8'h05);
    osdm_host_inst.wr(ADDR_GLYPH_DATA, 8'hA5);
    osdm_host_inst.wr(ADDR_GLYPH_CMD, 8'hA0);
    rdc(8'h88, 8'hA0, "busy cmd");
    osdm_host_inst.wr(ADDR_GLYPH_INDEX, 8'h33);
    rdc(8'h89, 8'h07, "index locked");
    osdm_host_inst.wait_idle(ok);
    chk("store idle", 8'h01, {7'h00, ok});
    rdc(8'h88, 8'h00, "cmd cleared");
    osdm_host_inst.wr(ADDR_GLYPH_DATA, 8'h00);
    osdm_host_inst.wr(ADDR_GLYPH_CMD, 8'h50);
    osdm_host_inst.wait_idle(ok);
    rdc(8'h8B, 8'hA5, "shadow");
    rdc(8'h8A, 8'h05, "byte index");
    // Clock enable low: the write must not land
    ce = 1'b0;
    osdm_host_inst.wr(ADDR_DISP_LOW, 8'h77);
    ce = 1'b1;
    rdc(8'h86, 8'h10, "frozen low");
    for (int i = 0; i < 8; i++) begin
      {sync_external, video_mode_background, local_background_bit} = 3'(i);
      @(posedge clk);
      @(posedge clk);
      #1 chk("background", (i == 4) ? 8'h01 : 8'h00, {7'h00, bg_shows_video});
    end
    end_of_test();
  end
endmodule : osd_memory_access_registers_test

bind osdm_memory_access osdm_checker #(.STORE_CYC(STORE_CYC), .CLEAR_CYC(CLEAR_CYC)) osdm_checker_inst (
  .clk(clk),
  .resetn(resetn),
  .ce(ce),
  .reg_wr_en(reg_wr_en),
  .reg_wr_addr(reg_wr_addr),
  .reg_wr_data(reg_wr_data),
  .reg_rd_en(reg_rd_en),
  .reg_rd_addr(reg_rd_addr),
  .reg_rd_data(reg_rd_data),
  .reg_rd_valid(reg_rd_valid),
  .display_access_mode_8bit(display_access_mode_8bit),
  .auto_inc_start(auto_inc_start),
  .clear_start(clear_start),
  .osd_enable(osd_enable),
  .sync_external(sync_external),
  .video_mode_background(video_mode_background),
  .local_background_bit(local_background_bit),
  .clear_busy(clear_busy),
  .auto_inc_active(auto_inc_active),
  .glyph_busy(glyph_busy),
  .bg_shows_video(bg_shows_video)
);
